//--- fifo_modes_cfg.svh
// Purpose: Register offsets, field positions, reset values for the FIFO block.
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data.
// Notes: Definitions only.
`ifndef FIFO_MODES_CFG_SVH
`define FIFO_MODES_CFG_SVH

// Register byte offsets.
`define CFG_REG_STATUS 8'h00
`define CFG_REG_AE_THR 8'h04
`define CFG_REG_AF_THR 8'h08
`define CFG_REG_INT_STAT 8'h0c
`define CFG_REG_INT_MASK 8'h10

// Status register fields.
`define CFG_ST_EMPTY 0
`define CFG_ST_AEMPTY 1
`define CFG_ST_FULL 2
`define CFG_ST_AFULL 3
`define CFG_ST_LVL_LSB 8

// Interrupt status and mask fields.
`define CFG_INT_UDF 0
`define CFG_INT_OVF 1
`define CFG_INT_W 2

// Reset values of the fill thresholds.
`define CFG_AE_THR_RST 8'h03
`define CFG_AF_THR_RST 8'h03

`endif

//--- fifo_modes_pkg.sv
// Purpose: Shared types of the FIFO block.
// Assumes: Nothing beyond the AXI4-Lite response encoding.
// Notes: Offsets and values live in fifo_modes_cfg.svh.
package fifo_modes_pkg;

  // AXI4-Lite response codes used by the slave.
  typedef enum logic [1:0]
  {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_e;

endpackage

//--- pipe_sync2.sv
// Purpose: Two-flop synchroniser, also used to release the reset.
// Assumes: The first flop is read only by the second.
// Notes: Asynchronous reset to zero; the clock enable freezes both stages.
`timescale 1ns/100ps
`default_nettype none
module pipe_sync2
#(
  parameter int WIDTH = 1
)
(
  // Clock, enable and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Data in and out.
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] out_q;

  // Both stages shift together so no logic ever sees the first stage.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_q <= '0;
      out_q <= '0;
    end
    else if (i_ce)
    begin
      meta_q <= i_d;
      out_q <= meta_q;
    end
  end

  assign o_q = out_q;

endmodule
`default_nettype wire

//--- configurable_fifo_modes.sv
// Purpose: FIFO with single-clock or pointer-synchronised mode and an AXI4-Lite register file.
// Assumes: DEPTH is a power of two from 2 to 128; producer and consumer share i_clk.
// Notes: Assertions and covers at the end of the module check the behaviour.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_modes_cfg.svh"
module configurable_fifo_modes
#(
  parameter int DATA_W = 32,
  parameter int DEPTH = 16,
  parameter bit SINGLE_CLK = 1'b1
)
(
  // Clock, enable and reset.
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_rst_b,
  // Producer port.
  input wire logic i_wr_en,
  input wire logic [DATA_W-1:0] i_wr_data,
  output logic o_full,
  output logic o_afull,
  output logic o_wr_err,
  // Consumer port.
  input wire logic i_rd_en,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_empty,
  output logic o_aempty,
  output logic o_rd_err,
  // AXI4-Lite write channels.
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output fifo_modes_pkg::axi_resp_e o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output fifo_modes_pkg::axi_resp_e o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Interrupt.
  output logic o_irq
);
  import fifo_modes_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);

  // Binary to gray, so only one bit moves per pointer step across a crossing.
  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Gray back to binary on the receiving side.
  function automatic logic [AW:0] from_gray(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    from_gray = b;
  endfunction

  logic rst_n;
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic [AW:0] wr_ptr_rd;
  logic [AW:0] rd_ptr_wr;
  logic [AW:0] rd_level;
  logic [AW:0] wr_level;
  logic [AW:0] free_cnt;
  logic [AW:0] ae_thr_q;
  logic [AW:0] af_thr_q;
  logic wr_fire;
  logic rd_fire;
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] head;
  logic [DATA_W-1:0] pop_data_q;
  logic [DATA_W-1:0] late_data_q;
  logic pop_q;
  logic rd_err_q;
  logic wr_err_q;
  logic [`CFG_INT_W-1:0] int_stat_q;
  logic [`CFG_INT_W-1:0] int_mask_q;
  logic [`CFG_INT_W-1:0] int_set;
  logic [`CFG_INT_W-1:0] int_clr;
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] rdata_q;
  axi_resp_e bresp_q;
  axi_resp_e rresp_q;
  logic do_write;
  logic wr_known;
  logic lane0;
  logic [31:0] rd_mux;
  logic rd_known;

  // Reset is taken at once but released through two flops onto rst_n.
  // This path ignores i_ce, otherwise a frozen block could never leave reset.
  pipe_sync2 #(.WIDTH(1)) u_rst_sync
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(1'b1),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  // Pointer view per mode: direct in single mode, gray-synchronised otherwise.
  generate
    if (SINGLE_CLK)
    begin : g_single
      assign wr_ptr_rd = wr_ptr_q;
      assign rd_ptr_wr = rd_ptr_q;
    end
    else
    begin : g_dual
      logic [AW:0] wr_gray_q;
      logic [AW:0] rd_gray_q;
      logic [AW:0] wr_gray_s;
      logic [AW:0] rd_gray_s;

      // Gray copies come from flops so no glitch reaches the crossing.
      always_ff @(posedge i_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          wr_gray_q <= '0;
          rd_gray_q <= '0;
        end
        else if (i_ce)
        begin
          wr_gray_q <= to_gray(wr_ptr_q);
          rd_gray_q <= to_gray(rd_ptr_q);
        end
      end

      pipe_sync2 #(.WIDTH(AW+1)) u_wr_sync
      (
        .i_clk(i_clk),
        .i_rst_b(rst_n),
        .i_ce(i_ce),
        .i_d(wr_gray_q),
        .o_q(wr_gray_s)
      );

      pipe_sync2 #(.WIDTH(AW+1)) u_rd_sync
      (
        .i_clk(i_clk),
        .i_rst_b(rst_n),
        .i_ce(i_ce),
        .i_d(rd_gray_q),
        .o_q(rd_gray_s)
      );

      assign wr_ptr_rd = from_gray(wr_gray_s);
      assign rd_ptr_wr = from_gray(rd_gray_s);
    end
  endgenerate

  // Each flag uses its own pointer directly, so it asserts at once.
  // The far pointer arrives late in dual mode, so deassertion lags.
  assign rd_level = wr_ptr_rd - rd_ptr_q;
  assign wr_level = wr_ptr_q - rd_ptr_wr;
  assign free_cnt = DEPTH_L - wr_level;
  assign o_empty = (rd_level == '0);
  assign o_aempty = (rd_level <= ae_thr_q);
  assign o_full = (wr_level == DEPTH_L);
  assign o_afull = (free_cnt <= af_thr_q);
  assign wr_fire = i_ce & i_wr_en & ~o_full;
  assign rd_fire = i_ce & i_rd_en & ~o_empty;

  // Storage; a refused write never reaches it.
  always_ff @(posedge i_clk)
  begin
    if (wr_fire)
    begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_wr_data;
    end
  end

  // Write pointer; the new word is counted from the next cycle on.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
    end
    else if (wr_fire)
    begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  // Read pointer; moves only on an accepted read, independent of writes.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_q <= '0;
    end
    else if (rd_fire)
    begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  assign head = mem_q[rd_ptr_q[AW-1:0]];

  // Output register loads the oldest word on an accepted read only.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pop_q <= 1'b0;
      pop_data_q <= '0;
    end
    else if (i_ce)
    begin
      pop_q <= rd_fire;
      if (rd_fire)
      begin
        pop_data_q <= head;
      end
    end
  end

  // Dual mode adds one stage, trading a cycle of latency for timing slack.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      late_data_q <= '0;
    end
    else if (i_ce && pop_q)
    begin
      late_data_q <= pop_data_q;
    end
  end

  assign o_rd_data = SINGLE_CLK ? pop_data_q : late_data_q;

  // Error pulses, one cycle after the refused request.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_err_q <= 1'b0;
      wr_err_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rd_err_q <= i_rd_en & o_empty;
      wr_err_q <= i_wr_en & o_full;
    end
  end

  assign o_rd_err = rd_err_q;
  assign o_wr_err = wr_err_q;

  // Handshakes are gated by i_ce so no transfer is taken while frozen.
  assign o_s_axi_awready = i_ce & ~aw_have_q & ~bvalid_q;
  assign o_s_axi_wready = i_ce & ~w_have_q & ~bvalid_q;
  assign o_s_axi_bvalid = i_ce & bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = i_ce & ~rvalid_q;
  assign o_s_axi_rvalid = i_ce & rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign lane0 = do_write & w_strb_q[0];
  assign wr_known = (aw_addr_q == `CFG_REG_STATUS) || (aw_addr_q == `CFG_REG_AE_THR) ||
    (aw_addr_q == `CFG_REG_AF_THR) || (aw_addr_q == `CFG_REG_INT_STAT) ||
    (aw_addr_q == `CFG_REG_INT_MASK);

  // Address and data are held separately, so either may come first.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && i_s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Thresholds steer the low-fill and near-capacity flags.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ae_thr_q <= (AW+1)'(`CFG_AE_THR_RST);
      af_thr_q <= (AW+1)'(`CFG_AF_THR_RST);
      int_mask_q <= '0;
    end
    else if (i_ce && lane0)
    begin
      if (aw_addr_q == `CFG_REG_AE_THR)
      begin
        ae_thr_q <= w_data_q[AW:0];
      end
      if (aw_addr_q == `CFG_REG_AF_THR)
      begin
        af_thr_q <= w_data_q[AW:0];
      end
      if (aw_addr_q == `CFG_REG_INT_MASK)
      begin
        int_mask_q <= w_data_q[`CFG_INT_W-1:0];
      end
    end
  end

  // Sticky events; a set in the cycle of its write-one clear still wins.
  assign int_set[`CFG_INT_UDF] = i_ce & i_rd_en & o_empty;
  assign int_set[`CFG_INT_OVF] = i_ce & i_wr_en & o_full;
  assign int_clr = (lane0 && aw_addr_q == `CFG_REG_INT_STAT) ?
    w_data_q[`CFG_INT_W-1:0] : '0;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_stat_q <= '0;
    end
    else if (i_ce)
    begin
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
    end
  end

  assign o_irq = |(int_stat_q & int_mask_q);

  // Read decode; unmapped words read zero with an error response.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_known = 1'b1;
    case (i_s_axi_araddr)
      `CFG_REG_STATUS:
      begin
        rd_mux[`CFG_ST_EMPTY] = o_empty;
        rd_mux[`CFG_ST_AEMPTY] = o_aempty;
        rd_mux[`CFG_ST_FULL] = o_full;
        rd_mux[`CFG_ST_AFULL] = o_afull;
        rd_mux[`CFG_ST_LVL_LSB +: AW+1] = rd_level;
      end
      `CFG_REG_AE_THR: rd_mux[AW:0] = ae_thr_q;
      `CFG_REG_AF_THR: rd_mux[AW:0] = af_thr_q;
      `CFG_REG_INT_STAT: rd_mux[`CFG_INT_W-1:0] = int_stat_q;
      `CFG_REG_INT_MASK: rd_mux[`CFG_INT_W-1:0] = int_mask_q;
      default: rd_known = 1'b0;
    endcase
  end

  // Read answer is registered one cycle after the address is taken.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (i_s_axi_arvalid && o_s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && i_s_axi_rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  empty_clear_a: assert property (SINGLE_CLK && wr_fire && o_empty |=> !o_empty)
    else $error("Empty did not clear after a write.");
  underflow_flag_a: assert property (i_ce && i_rd_en && o_empty |=> o_rd_err)
    else $error("Read on empty did not flag underflow.");
  underflow_hold_a: assert property (SINGLE_CLK && i_ce && i_rd_en && o_empty
    |=> $stable(o_rd_data) && $stable(rd_ptr_q))
    else $error("Read on empty changed data or contents.");
  read_head_a: assert property (SINGLE_CLK && rd_fire |=> o_rd_data == $past(head))
    else $error("Read did not present the oldest word.");
  idle_hold_a: assert property (SINGLE_CLK && !i_rd_en |=> $stable(o_rd_data))
    else $error("Read data moved without a read.");
  low_fill_a: assert property (SINGLE_CLK && wr_fire && !rd_fire
    && rd_level == ae_thr_q |=> !o_aempty)
    else $error("Low-fill flag stayed after crossing the threshold.");
  last_word_a: assert property (SINGLE_CLK && rd_fire && !wr_fire
    && rd_level == 1 |=> o_empty && o_rd_data == $past(head))
    else $error("Last read did not empty with its data.");
  late_data_a: assert property (!SINGLE_CLK && rd_fire ##1 i_ce
    |=> o_rd_data == $past(head, 2))
    else $error("Dual mode data not one cycle late.");
  overflow_a: assert property (i_ce && i_wr_en && o_full
    |=> o_wr_err && $stable(wr_ptr_q))
    else $error("Write on full not refused and flagged.");
  near_cap_a: assert property (SINGLE_CLK && rd_fire && !wr_fire && o_afull
    && free_cnt == af_thr_q |=> !o_afull)
    else $error("Near-capacity did not drop after a read.");
  reset_state_a: assert property ($rose(rst_n) |-> o_empty && o_aempty
    && !o_rd_err && !o_wr_err)
    else $error("Flags wrong on reset release.");
  both_ops_a: assert property (SINGLE_CLK && rd_fire && wr_fire
    |=> rd_level == $past(rd_level))
    else $error("Simultaneous read and write changed the level.");

  fill_up_c: cover property (wr_fire ##1 o_full);
  drain_c: cover property (rd_fire ##1 o_empty);
  both_c: cover property (rd_fire && wr_fire);
  irq_c: cover property (o_irq);

endmodule
`default_nettype wire

//--- fifo_user_model.sv
// Purpose: Producer and consumer logic standing on the far side of the FIFO.
// Assumes: Shares the FIFO clock; requests change just after a rising edge.
// Notes: Released write data shows the inverse of the last word, so stale data never matches.
`timescale 1ns/100ps
`default_nettype none
module fifo_user_model
#(
  parameter int DATA_W = 32
)
(
  // Shared clock.
  input wire logic i_clk,
  // Requests towards the FIFO.
  output logic o_wr_en,
  output logic [DATA_W-1:0] o_wr_data,
  output logic o_rd_en
);
  // Idle at time zero so the FIFO sees no request during reset.
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_wr_data = '0;
  end

  // One request cycle, then release; results are settled by the falling edge.
  task automatic op(input logic w, input logic [DATA_W-1:0] d, input logic r);
    @(posedge i_clk);
    o_wr_en <= w;
    o_wr_data <= d;
    o_rd_en <= r;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wr_data <= ~d;
    o_rd_en <= 1'b0;
    @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- configurable_fifo_modes_tb.sv
// Purpose: Self-checking bench for the FIFO and its register file.
// Assumes: Single-clock device plus a pointer-synchronised copy, depth 8, thresholds of 3.
// Notes: A reference queue predicts every flag and data word after each request.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_modes_cfg.svh"
module configurable_fifo_modes_tb;
  import fifo_modes_pkg::*;
  localparam int DEPTH = 8;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic wr_en, rd_en, full, afull, wr_err, empty, aempty, rd_err, irq;
  logic [31:0] wr_data, rd_data, rdata;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  axi_resp_e bresp, rresp;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] ref_q[$];
  logic [31:0] last_rd = 32'h0;
  logic ce = 1'b1;
  logic [31:0] dual_data;
  logic dual_empty;

  // Clock at 20 MHz.
  always #25 i_clk = ~i_clk;

  fifo_user_model #(.DATA_W(32)) i_user (.i_clk(i_clk), .o_wr_en(wr_en), .o_wr_data(wr_data),
    .o_rd_en(rd_en));

  // Single mode is instanced with SINGLE_CLK on.
  configurable_fifo_modes #(.DATA_W(32), .DEPTH(DEPTH), .SINGLE_CLK(1'b1)) i_dut (
    .i_clk(i_clk), .i_ce(ce), .i_rst_b(i_rst_b), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .o_full(full), .o_afull(afull), .o_wr_err(wr_err), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .o_empty(empty), .o_aempty(aempty), .o_rd_err(rd_err), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_irq(irq));

  // Pointer-synchronised copy on the same requests; its register bus stays idle.
  configurable_fifo_modes #(.DATA_W(32), .DEPTH(DEPTH), .SINGLE_CLK(1'b0)) i_dut_dual (
    .i_clk(i_clk), .i_ce(ce), .i_rst_b(i_rst_b), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .o_full(), .o_afull(), .o_wr_err(), .i_rd_en(rd_en), .o_rd_data(dual_data),
    .o_empty(dual_empty), .o_aempty(), .o_rd_err(), .i_s_axi_awaddr(8'h00),
    .i_s_axi_awvalid(1'b0), .o_s_axi_awready(), .i_s_axi_wdata(32'h0000_0000),
    .i_s_axi_wstrb(4'h0), .i_s_axi_wvalid(1'b0), .o_s_axi_wready(), .o_s_axi_bresp(),
    .o_s_axi_bvalid(), .i_s_axi_bready(1'b0), .i_s_axi_araddr(8'h00),
    .i_s_axi_arvalid(1'b0), .o_s_axi_arready(), .o_s_axi_rdata(), .o_s_axi_rresp(),
    .o_s_axi_rvalid(), .i_s_axi_rready(1'b0), .o_irq());

  // Compare one value and count it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // AXI4-Lite write; both channels are offered together and released as each is taken.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) errors++;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  // AXI4-Lite read with expected data and response.
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) errors++;
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // One FIFO request, then every flag and the data word against the reference queue.
  task automatic xfer(input logic w, input logic [31:0] d, input logic r);
    logic was_full, was_empty;
    was_full = (ref_q.size() == DEPTH);
    was_empty = (ref_q.size() == 0);
    i_user.op(w, d, r);
    if (r && !was_empty) last_rd = ref_q.pop_front();
    if (w && !was_full) ref_q.push_back(d);
    check(rd_data, last_rd);
    check({31'h0, rd_err}, {31'h0, r && was_empty});
    check({31'h0, wr_err}, {31'h0, w && was_full});
    check({31'h0, empty}, {31'h0, ref_q.size() == 0});
    check({31'h0, full}, {31'h0, ref_q.size() == DEPTH});
    check({31'h0, aempty}, {31'h0, ref_q.size() <= 3});
    check({31'h0, afull}, {31'h0, DEPTH - ref_q.size() <= 3});
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial
  begin
    #(5000 * 50);
    errors++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    // Reset state and register table.
    xfer(1'b0, 32'h0, 1'b0);
    reg_rd(`CFG_REG_STATUS, 32'h3, RESP_OKAY);
    reg_rd(`CFG_REG_AE_THR, {24'h0, `CFG_AE_THR_RST}, RESP_OKAY);
    reg_rd(`CFG_REG_AF_THR, {24'h0, `CFG_AF_THR_RST}, RESP_OKAY);
    reg_rd(`CFG_REG_INT_MASK, 32'h0, RESP_OKAY);
    reg_rd(8'h20, 32'h0, RESP_SLVERR);
    reg_wr(8'h20, 32'h5, RESP_SLVERR);
    $display("test reset done");
    // Write and read together into an empty buffer, then a quiet cycle.
    xfer(1'b1, 32'ha0, 1'b1);
    check({31'h0, dual_empty}, 32'h1);
    xfer(1'b0, 32'h0, 1'b0);
    for (int k = 1; k < 4; k++) xfer(1'b1, 32'ha0 + k, 1'b0);
    check({31'h0, dual_empty}, 32'h0);
    xfer(1'b0, 32'h0, 1'b1);
    check(dual_data, 32'h0);
    xfer(1'b0, 32'h0, 1'b0);
    check(dual_data, 32'ha0);
    $display("test empty side done");
    // Fill to full, refuse, mixed requests at and below full.
    for (int k = 4; k < 9; k++) xfer(1'b1, 32'ha0 + k, 1'b0);
    xfer(1'b1, 32'hbad0, 1'b0);
    xfer(1'b1, 32'hbad1, 1'b1);
    xfer(1'b1, 32'hb0, 1'b1);
    reg_rd(`CFG_REG_STATUS, 32'h0708, RESP_OKAY);
    $display("test full side done");
    // Drain to empty, then read once more.
    while (ref_q.size() > 0) xfer(1'b0, 32'h0, 1'b1);
    xfer(1'b0, 32'h0, 1'b1);
    $display("test drain done");
    // Interrupts: both events are pending, masked, then unmasked and cleared.
    reg_rd(`CFG_REG_INT_STAT, 32'h3, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    reg_wr(`CFG_REG_INT_MASK, 32'h1, RESP_OKAY);
    check({31'h0, irq}, 32'h1);
    reg_wr(`CFG_REG_INT_STAT, 32'h1, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    reg_wr(`CFG_REG_INT_MASK, 32'h3, RESP_OKAY);
    check({31'h0, irq}, 32'h1);
    reg_wr(`CFG_REG_INT_STAT, 32'h2, RESP_OKAY);
    reg_rd(`CFG_REG_INT_STAT, 32'h0, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    // Freeze with two words stored, then reset in mid-run after a threshold change.
    xfer(1'b1, 32'hc0, 1'b0);
    xfer(1'b1, 32'hc1, 1'b0);
    @(posedge i_clk);
    ce <= 1'b0;
    i_user.op(1'b1, 32'hd0, 1'b1);
    @(posedge i_clk);
    ce <= 1'b1;
    check(rd_data, last_rd);
    check({31'h0, rd_err}, 32'h0);
    reg_rd(`CFG_REG_STATUS, 32'h0202, RESP_OKAY);
    reg_wr(`CFG_REG_AE_THR, 32'h0, RESP_OKAY);
    reg_rd(`CFG_REG_AE_THR, 32'h0, RESP_OKAY);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clk);
    ref_q.delete();
    last_rd = 32'h0;
    xfer(1'b0, 32'h0, 1'b0);
    reg_rd(`CFG_REG_AE_THR, {24'h0, `CFG_AE_THR_RST}, RESP_OKAY);
    $display("test freeze and reset done");
    test_done();
  end
endmodule
`default_nettype wire
